// >>> design/slb_pkg.sv
// shared constants and types for the synthesizer latch bank
package slb_pkg;
	localparam int WORD_W = 24;
	localparam int SEL_W = 2;
	// latch select codes in the two low bits
	localparam logic [1:0] SEL_MAIN = 2'h0;
	localparam logic [1:0] SEL_REF = 2'h1;
	localparam logic [1:0] SEL_FB = 2'h2;
	localparam logic [1:0] SEL_TEST = 2'h3;
	// main setup word fields
	localparam int MAIN_PRESC_HI = 23;
	localparam int MAIN_PRESC_LO = 22;
	localparam int MAIN_PD_MODE = 21;
	localparam int MAIN_PD_REQ = 20;
	localparam int MAIN_PUMP_GAIN = 10;
	localparam int MAIN_PUMP_TRI = 9;
	localparam int MAIN_DIV_RESET = 4;
	// feedback divider word fields
	localparam int FB_HALF_SEL = 23;
	localparam int FB_HALVING = 22;
	localparam int FB_PUMP_GAIN = 21;
	localparam int FB_B_MSB = 20;
	localparam int FB_B_LSB = 8;
	localparam int FB_RSV = 7;
	localparam int FB_A_MSB = 6;
	localparam int FB_A_LSB = 2;
	// reference divider word fields
	localparam int REF_BAND_HI = 21;
	localparam int REF_BAND_LO = 20;
	localparam int REF_TEST = 19;
	localparam int REF_LOCK_PREC = 18;
	localparam int REF_BACKLASH_HI = 17;
	localparam int REF_BACKLASH_LO = 16;
	localparam int REF_CNT_MSB = 15;
	localparam int REF_CNT_LSB = 2;
	// reset values of the latches
	localparam logic [23:0] WORD_RESET = 24'h000000;
	// edges of the reference divider output before sync power-down
	localparam logic [1:0] SYNC_PD_EDGES = 2'h2;

	// decoded feedback divider controls
	typedef struct packed {
		logic halved_prescaler_input_sel;
		logic output_halving;
		logic [12:0] b_count;
		logic [4:0] a_count;
	} slb_fb_type;

	// decoded reference divider controls
	typedef struct packed {
		logic [1:0] band_clock_div;
		logic factory_test_bit;
		logic lock_precision;
		logic [1:0] backlash_width;
		logic [13:0] ref_count;
	} slb_ref_type;

	// power-down actions driven into the core
	typedef struct packed {
		logic counters_load;
		logic pump_tristate;
		logic lock_detect_reset;
		logic rf_bias_en;
		logic ref_buffer_en;
	} slb_pd_type;

	typedef enum logic [1:0] {
		PD_OFF,
		PD_PENDING,
		PD_ON
	} slb_pd_state_type;
endpackage : slb_pkg

// >>> design/slb_shift_in.sv
// serial shift register and strobe edge detector for the latch bank
module slb_shift_in
	import slb_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe,
	output logic [23:0] shift_word,
	output logic strobe_rise
);
	logic sclk_q;
	logic strobe_q;
	logic [23:0] shift_q;

	////////////////////////////////////////////////////////////////////////
	// previous pin levels for edge detection
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			sclk_q <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			sclk_q <= serial_clock;
			strobe_q <= latch_strobe;
		end
	end

	// msb first: new bit enters at the bottom, old bits move up
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shift_q <= WORD_RESET;
		end else if (serial_clock && !sclk_q) begin
			shift_q <= {shift_q[22:0], serial_data}; // RL1
		end
	end

	assign shift_word = shift_q;
	assign strobe_rise = latch_strobe && !strobe_q; // RL1
endmodule : slb_shift_in

// >>> design/slb_sync_pd.sv
// counts reference divider output edges for synchronous power-down
module slb_sync_pd
	import slb_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic arm,
	input wire logic cancel,
	input wire logic ref_div_out,
	output logic fire
);
	logic ref_q;
	logic armed_q;
	logic [1:0] count_q;
	logic ref_rise;

	assign ref_rise = ref_div_out && !ref_q;

	////////////////////////////////////////////////////////////////////////
	// edge detect on the divider output
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_q <= 1'b0;
		end else begin
			ref_q <= ref_div_out;
		end
	end

	// counting starts only after the strobe; an edge in the arm cycle
	// itself is not counted, since it came before the strobe settled
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			armed_q <= 1'b0;
			count_q <= 2'h0;
		end else if (cancel) begin
			armed_q <= 1'b0; // RL24
			count_q <= 2'h0;
		end else if (arm) begin
			armed_q <= 1'b1; // RL24
			count_q <= 2'h0;
		end else if (fire) begin
			armed_q <= 1'b0;
			count_q <= 2'h0;
		end else if (armed_q && ref_rise) begin
			count_q <= count_q + 2'h1;
		end
	end

	// second edge after the strobe
	assign fire = armed_q && ref_rise && !cancel && !arm
		&& (count_q == SYNC_PD_EDGES - 2'h1); // RL6
endmodule : slb_sync_pd

// >>> design/slb_latch_bank.sv
// programming latches and power-down control of the synthesizer
// Notes on behaviour
// RL1 - host shifts 24 bits msb first; strobe rise copies word to latch
// RL2 - low bits 00 load the main setup latch on the strobe
// RL3 - prescaler select comes from main setup bits 23 and 22
// RL4 - main setup bit 21 is mode type, bit 20 power-down request
// RL5 - request with mode type 0 powers down on the latch event
// RL6 - request with mode type 1 powers down on second divider edge
// RL7 - chip enable low disables the device at once
// RL8 - power-down forces dividers and timeout counter to load state
// RL9 - power-down three-states the charge pump
// RL10 - power-down resets the digital lock detect
// RL11 - power-down removes the rf output stage bias enable
// RL12 - power-down disables the reference input buffer
// RL13 - shifting and latching keep working during power-down
// RL14 - host writes reference, then main setup, then feedback word
// RL15 - first main setup write powers up and starts bias settling
// RL16 - host waits settling time between main setup and feedback
// RL17 - power-up relocks without reprogramming when band was kept
// RL18 - host must not change feedback word during power-down
// RL19 - feedback word holds b count, reserved bit, a count, controls
// RL20 - reference word holds ref count, backlash, precision, band div
// RL21 - main setup bit 4 holds dividers in reset while set
// RL22 - pump gain follows whichever latch wrote it last
// RL23 - power-down holds until request cleared or chip enable high; here power-up needs both cleared request and chip enable high
// RL24 - sync power-down counts after strobe and cancels if cleared
module slb_latch_bank
	import slb_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic serial_clock,
	input wire logic serial_data,
	input wire logic latch_strobe,
	input wire logic chip_enable,
	input wire logic ref_div_out,
	output logic [23:0] main_setup_word,
	output logic [1:0] prescaler_sel,
	output logic pump_gain_sel,
	output slb_fb_type fb_ctrl,
	output slb_ref_type ref_ctrl,
	output slb_pd_type pd_ctrl,
	output logic divider_reset,
	output logic powered_up,
	output logic band_select_start,
	output logic fb_written_in_pd
);
	logic [23:0] shift_word;
	logic strobe_rise;
	logic [23:0] main_q;
	logic [23:0] fb_q;
	logic [23:0] ref_q;
	logic main_valid_q;
	logic gain_q;
	logic sync_fire;
	logic sync_arm;
	logic sync_cancel;
	logic load_main;
	logic load_fb;
	logic load_ref;
	logic new_req;
	logic new_mode;
	logic sw_pd;
	logic device_off;
	logic band_q;
	logic fb_dirty_q;
	logic load_q;
	logic tri_q;
	logic ld_reset_q;
	logic rf_bias_q;
	logic ref_buf_q;
	slb_pd_state_type pd_state_q;
	slb_pd_state_type pd_state_d;

	// latch destination decode, used for every strobe
	function automatic logic sel_is(input logic [23:0] w,
		input logic [1:0] code);
		sel_is = (w[1:0] == code);
	endfunction : sel_is

	// a request that powers down at once, as carried by a main word
	function automatic logic async_req(input logic req, input logic mode);
		async_req = req && !mode; // RL5
	endfunction : async_req

	// a request that waits for divider edges before powering down
	function automatic logic sync_req(input logic req, input logic mode);
		sync_req = req && mode; // RL6
	endfunction : sync_req

	////////////////////////////////////////////////////////////////////////
	// input register keeps running in power-down by design
	slb_shift_in u_shift (
		.clock(clock),
		.nrst(nrst),
		.serial_clock(serial_clock),
		.serial_data(serial_data),
		.latch_strobe(latch_strobe),
		.shift_word(shift_word),
		.strobe_rise(strobe_rise)
	); // RL13

	// test latch code is accepted but ignored
	assign load_main = strobe_rise && sel_is(shift_word, SEL_MAIN); // RL2
	assign load_ref = strobe_rise && sel_is(shift_word, SEL_REF);
	assign load_fb = strobe_rise && sel_is(shift_word, SEL_FB);

	// request bits of the word now being latched
	assign new_req = shift_word[MAIN_PD_REQ]; // RL4
	assign new_mode = shift_word[MAIN_PD_MODE]; // RL4

	////////////////////////////////////////////////////////////////////////
	// the three latches; contents survive power-down
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			main_q <= WORD_RESET;
		end else if (load_main) begin
			main_q <= shift_word; // RL2
		end
	end

	// feedback word; a load here while powered up also starts band selection
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fb_q <= WORD_RESET;
		end else if (load_fb) begin
			fb_q <= shift_word; // RL19
		end
	end

	// reference word; its count sets the divider output we watch
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_q <= WORD_RESET;
		end else if (load_ref) begin
			ref_q <= shift_word; // RL20
		end
	end

	// pump gain has two write paths; last write wins
	// the two loads are exclusive, so the branch order is moot
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			gain_q <= 1'b0;
		end else if (load_main) begin
			gain_q <= shift_word[MAIN_PUMP_GAIN]; // RL22
		end else if (load_fb) begin
			gain_q <= shift_word[FB_PUMP_GAIN]; // RL22
		end
	end

	////////////////////////////////////////////////////////////////////////
	// device stays down after reset until the first main setup write
	// so the core never runs on a main setup word that was never programmed
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			main_valid_q <= 1'b0;
		end else if (load_main) begin
			main_valid_q <= 1'b1; // RL15
		end
	end

	// sync entry: arm on a mode-1 request, cancel on a cleared request
	assign sync_arm = load_main && sync_req(new_req, new_mode)
		&& pd_state_q == PD_OFF;
	assign sync_cancel = load_main && !new_req; // RL24

	// fire is a one-cycle pulse on the second divider edge
	slb_sync_pd u_sync (
		.clock(clock),
		.nrst(nrst),
		.arm(sync_arm),
		.cancel(sync_cancel),
		.ref_div_out(ref_div_out),
		.fire(sync_fire)
	);

	// software power-down state
	// a mode-0 request overtakes a pending synchronous entry
	always_comb begin
		pd_state_d = pd_state_q;
		case (pd_state_q)
			PD_OFF: begin
				if (load_main && async_req(new_req, new_mode)) begin
					pd_state_d = PD_ON; // RL5
				end else if (sync_arm) begin
					pd_state_d = PD_PENDING; // RL6
				end
			end
			PD_PENDING: begin
				if (sync_cancel) begin
					pd_state_d = PD_OFF; // RL24
				end else if (load_main && async_req(new_req, new_mode)) begin
					pd_state_d = PD_ON; // RL5
				end else if (sync_fire) begin
					pd_state_d = PD_ON; // RL6
				end
			end
			PD_ON: begin
				if (sync_cancel) begin
					pd_state_d = PD_OFF; // RL23
				end
			end
			default: begin
				pd_state_d = PD_OFF;
			end
		endcase
	end

	// state register for the software power-down
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pd_state_q <= PD_OFF;
		end else begin
			pd_state_q <= pd_state_d;
		end
	end

	// software request alone, before the hardware override
	assign sw_pd = (pd_state_q == PD_ON);
	// chip enable overrides both request bits without delay
	assign device_off = !chip_enable || sw_pd || !main_valid_q; // RL7

	////////////////////////////////////////////////////////////////////////
	// band retained across power-down unless feedback word changes
	// the flag tells the host that a full reprogramming is now owed
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			fb_dirty_q <= 1'b0;
		end else if (load_fb && device_off) begin
			fb_dirty_q <= 1'b1; // RL18
		end else if (load_fb) begin
			fb_dirty_q <= 1'b0;
		end
	end

	// band select runs on a feedback write while up; a power-up alone
	// does not retrigger it, so the kept band is reused
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			band_q <= 1'b0;
		end else begin
			band_q <= load_fb && !device_off; // RL17
		end
	end

	////////////////////////////////////////////////////////////////////////
	// power-down actions toward the core, one flop per action; all share
	// the off condition so they move together on the same edge
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			load_q <= 1'b1;
		end else begin
			load_q <= device_off; // RL8
		end
	end

	// the user three-state bit may also park the pump while powered
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tri_q <= 1'b1;
		end else begin
			tri_q <= device_off || main_q[MAIN_PUMP_TRI]; // RL9
		end
	end

	// lock detect starts over after every power-down
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ld_reset_q <= 1'b1;
		end else begin
			ld_reset_q <= device_off; // RL10
		end
	end

	// rf stage bias; removing it leaves the outputs floating
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rf_bias_q <= 1'b0;
		end else begin
			rf_bias_q <= !device_off; // RL11
		end
	end

	// reference buffer; off so the reference pin is not loaded
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			ref_buf_q <= 1'b0;
		end else begin
			ref_buf_q <= !device_off; // RL12
		end
	end

	// status for the core, same timing as the action flops
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			powered_up <= 1'b0;
		end else begin
			powered_up <= !device_off;
		end
	end

	// action flops gathered into the carrier struct
	assign pd_ctrl.counters_load = load_q;
	assign pd_ctrl.pump_tristate = tri_q;
	assign pd_ctrl.lock_detect_reset = ld_reset_q;
	assign pd_ctrl.rf_bias_en = rf_bias_q;
	assign pd_ctrl.ref_buffer_en = ref_buf_q;

	// divider reset from the control bit
	// registered so the counters see one clean level per latch write
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			divider_reset <= 1'b1;
		end else begin
			divider_reset <= main_q[MAIN_DIV_RESET]; // RL21
		end
	end

	////////////////////////////////////////////////////////////////////////
	// field decode straight from the latch flops
	assign main_setup_word = main_q;
	assign prescaler_sel = main_q[MAIN_PRESC_HI:MAIN_PRESC_LO]; // RL3
	assign pump_gain_sel = gain_q;

	// feedback divider fields
	assign fb_ctrl.halved_prescaler_input_sel = fb_q[FB_HALF_SEL];
	assign fb_ctrl.output_halving = fb_q[FB_HALVING];
	assign fb_ctrl.b_count = fb_q[FB_B_MSB:FB_B_LSB]; // RL19
	assign fb_ctrl.a_count = fb_q[FB_A_MSB:FB_A_LSB]; // RL19

	// reference divider fields
	assign ref_ctrl.band_clock_div = ref_q[REF_BAND_HI:REF_BAND_LO];
	assign ref_ctrl.factory_test_bit = ref_q[REF_TEST];
	assign ref_ctrl.lock_precision = ref_q[REF_LOCK_PREC];
	assign ref_ctrl.backlash_width =
		ref_q[REF_BACKLASH_HI:REF_BACKLASH_LO]; // RL20
	assign ref_ctrl.ref_count = ref_q[REF_CNT_MSB:REF_CNT_LSB]; // RL20

	// status toward the core and the host
	assign band_select_start = band_q;
	assign fb_written_in_pd = fb_dirty_q;
endmodule : slb_latch_bank

// >>> verification/slb_host.sv
// host model driving the three-wire programming port
module slb_host (
	input wire logic clock,
	output logic serial_clock,
	output logic serial_data,
	output logic latch_strobe
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		serial_clock = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one word, msb first, then a one-cycle strobe
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) begin
			@(posedge clock);
			#1 serial_clock = 1'b0;
			serial_data = w[i];
			@(posedge clock);
			#1 serial_clock = 1'b1;
		end
		// clock parks low; data flips so a stale bit is never reused
		@(posedge clock);
		#1 serial_clock = 1'b0;
		serial_data = ~w[0];
		latch_strobe = 1'b1;
		@(posedge clock);
		#1 latch_strobe = 1'b0;
	endtask : send
endmodule : slb_host

// >>> verification/slb_latch_bank_chk.sv
// port-level assertions for the latch bank
module slb_latch_bank_chk
	import slb_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic chip_enable,
	input wire logic [23:0] main_setup_word,
	input wire logic [1:0] prescaler_sel,
	input wire slb_pd_type pd_ctrl,
	input wire logic divider_reset,
	input wire logic powered_up,
	input wire logic fb_written_in_pd
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	a_ce_off: assert property (!chip_enable |=> !powered_up)
		else $error("powered up with chip enable low");
	a_async_pd: assert property ($changed(main_setup_word) &&
		main_setup_word[20] && !main_setup_word[21] |=> !powered_up)
		else $error("async power-down not entered");
	a_down_load: assert property (!powered_up |-> pd_ctrl.counters_load)
		else $error("counters not held in load while down");
	a_down_pump: assert property ($fell(powered_up) |->
		pd_ctrl.pump_tristate && pd_ctrl.lock_detect_reset)
		else $error("pump or lock detect not reset on power-down");
	a_down_debias: assert property (!powered_up |->
		!pd_ctrl.rf_bias_en && !pd_ctrl.ref_buffer_en)
		else $error("bias or buffer enabled while down");
	a_presc_copy: assert property (prescaler_sel == main_setup_word[23:22])
		else $error("prescaler select differs from main word");
	a_dreset_copy: assert property ($changed(main_setup_word) |=>
		divider_reset == main_setup_word[4])
		else $error("divider reset not following main bit 4");
	a_up_cause: assert property ($rose(powered_up) |->
		!main_setup_word[20] && $past(chip_enable))
		else $error("power-up without cleared request");
	a_fb_in_pd: assert property ($rose(fb_written_in_pd) |-> !powered_up)
		else $error("feedback write flagged while up");
endmodule : slb_latch_bank_chk

bind slb_latch_bank slb_latch_bank_chk chk (.clock, .nrst, .chip_enable,
	.main_setup_word, .prescaler_sel, .pd_ctrl, .divider_reset,
	.powered_up, .fb_written_in_pd);

// >>> verification/slb_latch_bank_tb_top.sv
// self-checking bench for the latch bank against a reference model
module slb_latch_bank_tb_top
	import slb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock, nrst, chip_enable, ref_div_out;
	logic serial_clock, serial_data, latch_strobe;
	logic [23:0] main_setup_word;
	logic [1:0] prescaler_sel;
	logic pump_gain_sel, divider_reset, powered_up;
	logic band_select_start, fb_written_in_pd;
	slb_fb_type fb_ctrl;
	slb_ref_type ref_ctrl;
	slb_pd_type pd_ctrl;
	logic [23:0] m_main, m_fb, m_ref;
	logic m_pg, m_down, m_written, m_dirty;
	int seed = 53;
	int n_errors = 0;
	int total_checks = 0;

	slb_latch_bank uut (.clock, .nrst, .serial_clock, .serial_data,
		.latch_strobe, .chip_enable, .ref_div_out, .main_setup_word,
		.prescaler_sel, .pump_gain_sel, .fb_ctrl, .ref_ctrl, .pd_ctrl,
		.divider_reset, .powered_up, .band_select_start, .fb_written_in_pd);
	slb_host host (.clock, .serial_clock, .serial_data, .latch_strobe);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [23:0] exp,
		input logic [23:0] got);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h got %h", name, exp, got);
		end
	endtask : chk

	// compares every result except band_select_start against the model
	task automatic check_all();
		logic up;
		up = m_written && !m_down && chip_enable;
		chk("main", m_main, main_setup_word);
		chk("presc", 24'(m_main[23:22]), 24'(prescaler_sel));
		chk("fb", 24'({m_fb[23:22], m_fb[20:8], m_fb[6:2]}), 24'(fb_ctrl));
		chk("ref", 24'(m_ref[21:2]), 24'(ref_ctrl));
		chk("gain", 24'(m_pg), 24'(pump_gain_sel));
		if (m_written)
			chk("dreset", 24'(m_main[4]), 24'(divider_reset));
		chk("up", 24'(up), 24'(powered_up));
		chk("rfbias", 24'(up), 24'(pd_ctrl.rf_bias_en));
		chk("refbuf", 24'(up), 24'(pd_ctrl.ref_buffer_en));
		chk("ldreset", 24'(!up), 24'(pd_ctrl.lock_detect_reset));
		chk("dirty", 24'(m_dirty), 24'(fb_written_in_pd));
		if (!up) begin
			chk("load", 24'h1, 24'(pd_ctrl.counters_load));
			chk("tri", 24'h1, 24'(pd_ctrl.pump_tristate));
		end else begin
			chk("tri", 24'(m_main[9]), 24'(pd_ctrl.pump_tristate));
		end
	endtask : check_all

	// a word for latch code c; main words keep mode type clear
	function automatic logic [23:0] rnd(input logic [1:0] c);
		logic [23:0] w;
		w = 24'($random(seed));
		w[1:0] = c;
		if (c == 2'h0)
			w[21] = 1'b0;
		return w;
	endfunction : rnd

	task automatic write(input logic [23:0] w);
		logic was_up;
		was_up = m_written && !m_down && chip_enable;
		host.send(w);
		// the band pulse stands only in the cycle after the load
		chk("band", 24'(was_up && w[1:0] == 2'h2), 24'(band_select_start));
		case (w[1:0])
			2'h0: begin
				m_main = w;
				m_pg = w[10];
				m_written = 1'b1;
				if (!w[20] || !w[21])
					m_down = w[20];
			end
			2'h1: m_ref = w;
			2'h2: begin
				m_fb = w;
				m_pg = w[21];
				m_dirty = !was_up;
			end
			default: ;
		endcase
		repeat (4) @(posedge clock);
		#1 check_all();
	endtask : write

	task automatic ref_edge();
		@(posedge clock);
		#1 ref_div_out = 1'b1;
		@(posedge clock);
		#1 ref_div_out = 1'b0;
		repeat (3) @(posedge clock);
		#1;
	endtask : ref_edge

	task automatic results();
		if (n_errors == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		chip_enable = 1'b1;
		ref_div_out = 1'b0;
		{m_main, m_fb, m_ref, m_pg, m_down, m_written, m_dirty} = '0;
		repeat (2) @(posedge clock);
		#1 nrst = 1'b1;
		check_all();
		write(rnd(2'h1));
		write(rnd(2'h0) & 24'hefffff);
		write(rnd(2'h2));
		write(rnd(2'h3));
		write(m_fb ^ 24'h200000);
		write(m_main ^ 24'h000400);
		write(m_main | 24'h100000);
		write(rnd(2'h1));
		write(rnd(2'h2));
		write(m_main ^ 24'h100000);
		// hardware disable overrides the software state
		chip_enable = 1'b0;
		repeat (3) @(posedge clock);
		#1 check_all();
		chip_enable = 1'b1;
		repeat (3) @(posedge clock);
		#1 check_all();
		write(m_main | 24'h300000);
		ref_edge();
		check_all();
		ref_edge();
		m_down = 1'b1;
		check_all();
		write(m_main ^ 24'h300000);
		// a pending entry is dropped when the request clears
		write(m_main | 24'h300000);
		ref_edge();
		write(m_main ^ 24'h100000);
		ref_edge();
		ref_edge();
		check_all();
		repeat (16) write(rnd(2'($random(seed))));
		results();
	end

	// long enough for every scenario several times over
	initial begin
		#400000;
		n_errors++;
		results();
	end
endmodule : slb_latch_bank_tb_top
